// ---- hw/gdas_pkg.sv ----
// package for the gate drive arming sequencer: command codes, reset values, gate states
// assumes one 125 MHz clock domain and a byte-wide serial engine outside this block
package gdas_pkg;
  // ****************************************
  // serial command decode
  // ****************************************
  localparam logic [7:0] GDAS_QUERY_MASK  = 8'he3;  // bits 4..2 are don't care
  localparam logic [7:0] GDAS_QUERY_CODE  = 8'h03;  // deadtime read-back query
  localparam logic [7:0] GDAS_CALIB_RESET = 8'h00;  // read-back value before calibration
  localparam logic [7:0] GDAS_DT_MAX      = 8'hff;  // deadtime in force after reset
  localparam logic [7:0] GDAS_STATUS0_DEF = 8'h00;  // general status when not a query

  // ****************************************
  // per-phase gate state
  // ****************************************
  typedef enum logic [2:0] {
    GDAS_HIZ,      // after reset, not yet armed
    GDAS_ARMED,    // low side commanded on, high side not yet toggled
    GDAS_HS_ON,    // high side commanded on once
    GDAS_LATCHED   // initialised, follows the phase inputs
  } gdas_phase_e;
endpackage : gdas_pkg

// ---- hw/gdas_core.sv ----
// gate drive arming sequencer: hold-off, tri-state, arming and latching per phase,
// plus the deadtime calibration read-back on the serial byte path.
// assumes phase and enable pins are asynchronous and the serial byte strobe is local.
module gdas_core
  import gdas_pkg::*;
#(
  parameter int PHASES = 3
)(
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              LOW_SIDE_SUPPLY_OK_I,
  input  wire logic              POWER_ON_RESET_I,
  input  wire logic              LOGIC_SUPPLY_OK_I,
  input  wire logic              FIRST_DRIVE_GATE_INPUT_I,
  input  wire logic              SECOND_DRIVE_GATE_INPUT_I,
  input  wire logic [PHASES-1:0] PHASE_LOW_CMD_I,
  input  wire logic [PHASES-1:0] PHASE_HIGH_CMD_N_I,
  input  wire logic              CMD_VALID_I,
  input  wire logic [7:0]        CMD_BYTE_I,
  input  wire logic              CALIB_VALID_I,
  input  wire logic [7:0]        CALIB_CODE_I,
  output logic      [7:0]        REPLY_BYTE_O,
  output logic      [7:0]        DEADTIME_O,
  output logic      [PHASES-1:0] LOW_GATE_O,
  output logic      [PHASES-1:0] LOW_GATE_OE_O,
  output logic      [PHASES-1:0] HIGH_GATE_O,
  output logic      [PHASES-1:0] HIGH_GATE_OE_O,
  output logic      [PHASES-1:0] HIGH_SRC_SHORT_O,
  output logic                   HOLD_OFF_O
);

  // elaboration check: every phase vector and the struct are sized from PHASES
  if (PHASES < 1 || PHASES > 8)
  begin : g_bad_phases
    $error("gdas_core: PHASES out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [PHASES-1:0]      lo_s1;
    logic [PHASES-1:0]      lo_s2;
    logic [PHASES-1:0]      lo_p;    // previous synced low command
    logic [PHASES-1:0]      hi_s1;
    logic [PHASES-1:0]      hi_s2;
    logic [PHASES-1:0]      hi_p;
    logic [1:0]             en_s1;
    logic [1:0]             en_s2;
    logic [2:0]             sup_s1;
    logic [2:0]             sup_s2;
    gdas_phase_e [PHASES-1:0] ph;
    logic [PHASES-1:0]      lo_drv;
    logic [PHASES-1:0]      lo_oe;
    logic [PHASES-1:0]      hi_drv;
    logic [PHASES-1:0]      hi_oe;
    logic [PHASES-1:0]      hs_short;
    logic                   hold;
    logic [7:0]             calib;
    logic [7:0]             dt;
    logic [7:0]             reply;
  } gdas_state_s;

  gdas_state_s s_q;
  gdas_state_s s_d;

  logic              en_ok;
  logic              supply_bad;
  logic [PHASES-1:0] lo_rise;
  logic [PHASES-1:0] hi_fall;
  logic [PHASES-1:0] hi_rise;

  // edges only on the second synchroniser stage, never the first
  assign en_ok      = &s_q.en_s2;
  assign supply_bad = ~s_q.sup_s2[0] | s_q.sup_s2[1] | ~s_q.sup_s2[2];
  assign lo_rise    = s_q.lo_s2 & ~s_q.lo_p;
  assign hi_fall    = ~s_q.hi_s2 & s_q.hi_p;
  assign hi_rise    = s_q.hi_s2 & ~s_q.hi_p;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.lo_s1  = PHASE_LOW_CMD_I;
    s_d.lo_s2  = s_q.lo_s1;
    s_d.lo_p   = s_q.lo_s2;
    s_d.hi_s1  = PHASE_HIGH_CMD_N_I;
    s_d.hi_s2  = s_q.hi_s1;
    s_d.hi_p   = s_q.hi_s2;
    s_d.en_s1  = {SECOND_DRIVE_GATE_INPUT_I, FIRST_DRIVE_GATE_INPUT_I};
    s_d.en_s2  = s_q.en_s1;
    s_d.sup_s1 = {LOGIC_SUPPLY_OK_I, POWER_ON_RESET_I, LOW_SIDE_SUPPLY_OK_I};
    s_d.sup_s2 = s_q.sup_s1;
    s_d.hold   = supply_bad;

    // per-phase arming; a high-side edge before arming is simply dropped
    for (int i = 0; i < PHASES; i++)
    begin
      if (en_ok)
      begin
        unique case (s_q.ph[i])
          GDAS_HIZ:
            if (lo_rise[i])
              s_d.ph[i] = GDAS_ARMED;
          GDAS_ARMED:
            if (hi_fall[i])
              s_d.ph[i] = GDAS_HS_ON;
          GDAS_HS_ON:
            if (hi_rise[i])
              s_d.ph[i] = GDAS_LATCHED;
          GDAS_LATCHED:
            s_d.ph[i] = GDAS_LATCHED;
          default:
            s_d.ph[i] = GDAS_HIZ;
        endcase
      end
      // low side drives once armed and enabled
      s_d.lo_oe[i]  = en_ok && (s_q.ph[i] != GDAS_HIZ);
      s_d.lo_drv[i] = en_ok && (s_q.ph[i] != GDAS_HIZ) && s_q.lo_s2[i];
      // high side tri-stated until it has been commanded at least once after arming
      s_d.hi_oe[i]  = (s_q.ph[i] == GDAS_HS_ON) || (s_q.ph[i] == GDAS_LATCHED);
      s_d.hi_drv[i] = en_ok && s_d.hi_oe[i] && ~s_q.hi_s2[i];
      s_d.hs_short[i] = s_d.hi_oe[i] && ~s_d.hi_drv[i];
      // hold-off wins over everything: gates driven low
      if (supply_bad)
      begin
        s_d.lo_oe[i]    = 1'b1;
        s_d.lo_drv[i]   = 1'b0;
        s_d.hi_oe[i]    = 1'b1;
        s_d.hi_drv[i]   = 1'b0;
        s_d.hs_short[i] = 1'b1;
      end
    end

    // calibration result from the serial engine
    if (CALIB_VALID_I)
    begin
      s_d.calib = CALIB_CODE_I;
      s_d.dt    = CALIB_CODE_I;
    end

    // the reply of a byte is returned in the next frame; the query touches nothing else
    if (CMD_VALID_I)
    begin
      if ((CMD_BYTE_I & GDAS_QUERY_MASK) == GDAS_QUERY_CODE)
        s_d.reply = s_q.calib;
      else
        s_d.reply = GDAS_STATUS0_DEF;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // synchronous reset: gates held off, phases back to tri-state
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      s_q          <= '0;
      s_q.ph       <= {PHASES{GDAS_HIZ}};
      s_q.hold     <= 1'b1;
      s_q.lo_oe    <= '1;
      s_q.hi_oe    <= '1;
      s_q.hs_short <= '1;
      s_q.calib    <= GDAS_CALIB_RESET;
      s_q.dt       <= GDAS_DT_MAX;
      s_q.reply    <= GDAS_STATUS0_DEF;
      // high-side commands idle high; a low history would fake a rise after reset
      s_q.hi_s1    <= '1;
      s_q.hi_s2    <= '1;
      s_q.hi_p     <= '1;
    end
    else
      s_q <= s_d;
  end

  assign REPLY_BYTE_O     = s_q.reply;
  assign DEADTIME_O       = s_q.dt;
  assign LOW_GATE_O       = s_q.lo_drv;
  assign LOW_GATE_OE_O    = s_q.lo_oe;
  assign HIGH_GATE_O      = s_q.hi_drv;
  assign HIGH_GATE_OE_O   = s_q.hi_oe;
  assign HIGH_SRC_SHORT_O = s_q.hs_short;
  assign HOLD_OFF_O       = s_q.hold;

  // ****************************************
  // checks
  // ****************************************
  // arming steps of phase a: each step needs its own input edge with both enables high
  sequence arm_seq;
    lo_rise[0] && en_ok && s_q.ph[0] == GDAS_HIZ;
  endsequence

  sequence hs_on_seq;
    hi_fall[0] && en_ok && s_q.ph[0] == GDAS_ARMED;
  endsequence

  sequence hs_off_seq;
    hi_rise[0] && en_ok && s_q.ph[0] == GDAS_HS_ON && !supply_bad;
  endsequence

  query_reply_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CMD_VALID_I && ((CMD_BYTE_I & GDAS_QUERY_MASK) == GDAS_QUERY_CODE) && !CALIB_VALID_I
    |=> REPLY_BYTE_O == $past(s_q.calib))
    else $error("query reply wrong");

  query_pure_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CMD_VALID_I && !CALIB_VALID_I |=> $stable(DEADTIME_O) && $stable(s_q.calib))
    else $error("query altered state");

  hold_low_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    supply_bad |=> HOLD_OFF_O && LOW_GATE_O == '0 && HIGH_GATE_O == '0)
    else $error("gates not held low");

  hiz_start_a: assert property (@(posedge CLK_I)
    $rose(RST_N_I) |=> s_q.ph[0] == GDAS_HIZ)
    else $error("phase not tri-state after reset");

  dt_max_a: assert property (@(posedge CLK_I)
    !RST_N_I |=> DEADTIME_O == GDAS_DT_MAX && s_q.calib == GDAS_CALIB_RESET)
    else $error("reset deadtime wrong");

  enable_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !en_ok |=> $stable(s_q.ph))
    else $error("phase moved while disabled");

  arm_first_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_q.ph[0] == GDAS_HIZ && !(lo_rise[0] && en_ok) |=> s_q.ph[0] == GDAS_HIZ)
    else $error("high side armed without low side");

  arm_step_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    arm_seq |=> s_q.ph[0] == GDAS_ARMED)
    else $error("low-side rise did not arm");

  hs_step_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hs_on_seq |=> s_q.ph[0] == GDAS_HS_ON ##1 HIGH_GATE_OE_O[0])
    else $error("high side not taken out of tri-state");

  latch_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    hs_off_seq
    |=> HIGH_GATE_OE_O[0] && HIGH_SRC_SHORT_O[0] && s_q.ph[0] == GDAS_LATCHED)
    else $error("high side not latched off");

  stay_init_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_q.ph[0] == GDAS_LATCHED |=> s_q.ph[0] == GDAS_LATCHED)
    else $error("initialised phase lost");

  // once the supplies are good the hold-off lets go, and an unarmed phase
  // leaves both gates floating rather than guessing a level
  release_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !supply_bad |=> !HOLD_OFF_O)
    else $error("hold-off not released");

  hiz_gates_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_q.ph[0] == GDAS_HIZ && !supply_bad
    |=> !LOW_GATE_OE_O[0] && !HIGH_GATE_OE_O[0])
    else $error("unarmed phase driven");

  // after initialisation both gates follow the synchronised commands one cycle later
  gate_follow_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_q.ph[0] == GDAS_LATCHED && en_ok && !supply_bad
    |=> LOW_GATE_OE_O[0] && HIGH_GATE_OE_O[0]
        && LOW_GATE_O[0] == $past(s_q.lo_s2[0])
        && HIGH_SRC_SHORT_O[0] == $past(s_q.hi_s2[0]))
    else $error("initialised gates not following commands");

  // a new calibration code takes effect as both deadtime and read-back value
  calib_load_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    CALIB_VALID_I
    |=> DEADTIME_O == $past(CALIB_CODE_I) && s_q.calib == $past(CALIB_CODE_I))
    else $error("calibration code not taken");

  // the reply stands until the next byte, so a late fetch by the serial engine still sees it
  reply_stand_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !CMD_VALID_I |=> $stable(REPLY_BYTE_O))
    else $error("reply changed without a command");

endmodule : gdas_core

// ---- tb/gdas_host.sv ----
// host model: drives the two enables and the six phase commands of the arming sequence
// assumes the bench calls its tasks right after a falling edge of clk_i
module gdas_host #(
  parameter int HS_CYC = 45  // deadtime plus 100 ns, in clock cycles
)(
  input  wire logic       clk_i,
  output logic            en1_o,
  output logic            en2_o,
  output logic [2:0]      low_o,
  output logic [2:0]      high_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // arming sequence
  // ****************************************
  // enables stay low until the configuration bytes are sent
  initial
  begin
    en1_o    = 1'b0;
    en2_o    = 1'b0;
    low_o    = 3'h0;
    high_n_o = 3'h7;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  // both enables together, after the disabled arming attempt, then 35 cycles before any low rise
  task automatic enable(input logic on);
    en1_o = on;
    en2_o = on;
    cyc(35);
  endtask : enable

  // lo_cyc of 0 skips the low pulse, which is how a misordered host looks
  task automatic arm(input int lo_cyc);
    if (lo_cyc > 0)
    begin
      low_o = 3'h7;  // 125 cycles full, 13 on recovery
      cyc(lo_cyc);
      low_o = 3'h0;
    end
    high_n_o = 3'h0;  // all three at once, no gap after the low pulse
    cyc(HS_CYC);
    high_n_o = 3'h7;
  endtask : arm

  // steady command levels for checking normal operation after initialisation
  task automatic drive(input logic [2:0] lo, input logic [2:0] hi_n);
    low_o    = lo;
    high_n_o = hi_n;
  endtask : drive
endmodule : gdas_host

// ---- tb/tb.sv ----
// testbench: serial byte and calibration tasks plus arming scenarios through the host model
// assumes a 125 MHz clock and the registered timings of the core
module tb import gdas_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, vls_ok, por, vdd_ok, en1, en2, cmd_v, cal_v, hold;
  logic [7:0] cmd_b, cal_b, reply, dt;
  logic [2:0] lo, hi_n, lg, lg_oe, hg, hg_oe, short;
  int         n_errors = 0;
  int         samples_checked = 0;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  gdas_core i_gdas_core (.CLK_I(clk), .RST_N_I(rst_n), .LOW_SIDE_SUPPLY_OK_I(vls_ok),
    .POWER_ON_RESET_I(por), .LOGIC_SUPPLY_OK_I(vdd_ok), .FIRST_DRIVE_GATE_INPUT_I(en1),
    .SECOND_DRIVE_GATE_INPUT_I(en2), .PHASE_LOW_CMD_I(lo), .PHASE_HIGH_CMD_N_I(hi_n),
    .CMD_VALID_I(cmd_v), .CMD_BYTE_I(cmd_b), .CALIB_VALID_I(cal_v), .CALIB_CODE_I(cal_b),
    .REPLY_BYTE_O(reply), .DEADTIME_O(dt), .LOW_GATE_O(lg), .LOW_GATE_OE_O(lg_oe),
    .HIGH_GATE_O(hg), .HIGH_GATE_OE_O(hg_oe), .HIGH_SRC_SHORT_O(short), .HOLD_OFF_O(hold));
  gdas_host i_gdas_host (.clk_i(clk), .en1_o(en1), .en2_o(en2), .low_o(lo), .high_n_o(hi_n));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle strobe: a command byte when q is set, else a calibration code
  task automatic pulse(input logic q, input logic [7:0] b);
    cmd_b = b;
    cal_b = b;
    cmd_v = q;
    cal_v = ~q;
    @(negedge clk);
    cmd_v = 1'b0;
    cal_v = 1'b0;
    @(negedge clk);
  endtask : pulse

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // a hang is cut well beyond the roughly 670 cycles the tests take
  initial
  begin
    repeat (5000) @(negedge clk);
    n_errors++;
    end_sim();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    rst_n  = 1'b0;
    por    = 1'b0;
    vls_ok = 1'b1;
    vdd_ok = 1'b1;
    cmd_v  = 1'b0;
    cal_v  = 1'b0;
    cmd_b  = 8'h00;
    cal_b  = 8'h00;
    repeat (2) @(negedge clk);
    chk(dt, GDAS_DT_MAX);
    chk({1'b0, hold, lg, hg}, 8'h40);
    rst_n = 1'b1;
    i_gdas_host.cyc(50);                   // shortened supply settling
    chk({7'h0, hold}, 8'h00);
    chk({2'h0, lg_oe, hg_oe}, 8'h00);
    pulse(1'b1, 8'h03);
    chk(reply, GDAS_CALIB_RESET);
    pulse(1'b0, 8'h5a);
    for (int i = 0; i < 8; i++)
    begin
      pulse(1'b1, {3'h0, i[2:0], 2'h3});
      chk(reply, 8'h5a);
      chk(dt, 8'h5a);
      pulse(1'b1, {i[2:0], 5'h03});
      chk(reply, (i == 0) ? 8'h5a : GDAS_STATUS0_DEF);
    end
    i_gdas_host.arm(125);
    i_gdas_host.cyc(6);
    chk({2'h0, lg_oe, hg_oe}, 8'h00);
    i_gdas_host.enable(1'b1);
    i_gdas_host.arm(0);
    i_gdas_host.cyc(6);
    chk({5'h0, hg_oe}, 8'h00);
    i_gdas_host.arm(125);
    i_gdas_host.cyc(6);
    chk({2'h0, lg_oe, hg_oe}, 8'h3f);
    chk({2'h0, short, hg}, 8'h38);
    i_gdas_host.arm(13);
    pulse(1'b1, 8'h1f);
    i_gdas_host.cyc(6);
    chk({2'h0, lg_oe, hg_oe}, 8'h3f);
    chk(reply, 8'h5a);
    // low sides a and c on, high side b on: one supply fault at a time must override both
    i_gdas_host.drive(3'h5, 3'h5);
    for (int k = 0; k < 3; k++)
    begin
      vls_ok = (k != 0);
      por    = (k == 1);
      vdd_ok = (k != 2);
      i_gdas_host.cyc(5);
      chk({1'b0, hold, lg, hg}, 8'h40);
      chk({2'h0, short, 3'h0}, 8'h38);
      vls_ok = 1'b1;
      por    = 1'b0;
      vdd_ok = 1'b1;
      i_gdas_host.cyc(5);
      chk({1'b0, hold, lg, hg}, 8'h2a);
      chk({5'h0, short}, 8'h05);
    end
    // idle commands and enables low, so nothing looks like an edge after the reset
    i_gdas_host.drive(3'h0, 3'h7);
    i_gdas_host.enable(1'b0);
    rst_n = 1'b0;
    i_gdas_host.cyc(2);
    rst_n = 1'b1;
    i_gdas_host.cyc(10);
    chk({2'h0, lg_oe, hg_oe}, 8'h00);
    chk({7'h0, hold}, 8'h00);
    chk(dt, GDAS_DT_MAX);
    pulse(1'b1, 8'h03);
    chk(reply, GDAS_CALIB_RESET);
    end_sim();
  end
endmodule : tb
